// ---- sim/bdr_bench.sv ----
module bdr_bench
  import bdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, req = 1'b0, req_write = 1'b0;
  logic pll_enable = 1'b1, term_high = 1'b1;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [BURST_W-1:0] req_wdata = '0, rd_data;
  logic [LANES-1:0] req_be_n = 8'hFF;
  logic [ZCODE_W-1:0] impedance_reference = 6'h15, drive_code;
  logic req_ready, rd_valid, link_ready, pll_locked, term_range_high, impedance_update;
  int err_count = 0, total_checks = 0, lat [2], n;
  logic [BURST_W-1:0] mem [logic [ADDR_W-1:0]];

  always #25 clk = ~clk;

  // single bank, so the one load line is never shared
  bdr_if bdr_if_i ();
  bdr_device bdr_device_i (.clk(clk), .srst(srst), .lnk(bdr_if_i.dev),
    .impedance_reference(impedance_reference), .pll_locked(pll_locked),
    .term_range_high(term_range_high), .drive_code(drive_code),
    .impedance_update(impedance_update));
  bdr_host bdr_host_i (.clk(clk), .srst(srst), .lnk(bdr_if_i.host), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be_n(req_be_n),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .link_ready(link_ready),
    .pll_enable(pll_enable), .term_high(term_high));
  bdr_checker bdr_checker_i (.clk(clk), .srst(srst), .k(bdr_if_i.k), .load_n(bdr_if_i.load_n),
    .read_not_write(bdr_if_i.read_not_write), .byte_write_select_n(bdr_if_i.byte_write_select_n),
    .host_dq_oe(bdr_if_i.host_dq_oe), .dev_dq_oe(bdr_if_i.dev_dq_oe),
    .echo_clock(bdr_if_i.echo_clock), .echo_clock_n(bdr_if_i.echo_clock_n),
    .read_valid_flag(bdr_if_i.read_valid_flag));

  task automatic check(input logic [BURST_W-1:0] seen, input logic [BURST_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // request stays up until taken; the caller decides whether to drop it
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [BURST_W-1:0] d, input logic [LANES-1:0] be);
    int c;
    c = 0;
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_be_n <= be;
    do begin
      @(negedge clk);
      c++;
    end while (req_ready !== 1'b1 && c < 100);
    check(c < 100, 1'b1);
    @(posedge clk);
  endtask : access

  // fold only the enabled bytes into the expected image
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BURST_W-1:0] d,
                    input logic [LANES-1:0] be);
    logic [BURST_W-1:0] img;
    img = mem.exists(a) ? mem[a] : 'x;
    for (int i = 0; i < LANES; i++) begin
      if (!be[i]) img[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
    end
    mem[a] = img;
    access(1'b1, a, d, be);
  endtask : wr

  // latency to the first driven word is kept per mode for comparison
  task automatic rd(input logic [ADDR_W-1:0] a, input int m);
    int c;
    access(1'b0, a, '0, 8'hFF);
    req <= 1'b0;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (bdr_if_i.dev_dq_oe !== 1'b1 && c < 200);
    lat[m] = c;
    do begin
      @(negedge clk);
      c++;
    end while (rd_valid !== 1'b1 && c < 300);
    check(rd_data, mem[a]);
    @(posedge clk);
  endtask : rd

  // pll mode first, then legacy mode after a second reset
  initial begin
    for (int m = 0; m < 2; m++) begin
      pll_enable <= (m == 0);
      term_high <= (m == 0);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      check(bdr_if_i.dev_dq_oe, 1'b0);
      check(drive_code, ZCODE_RST);
      repeat (5) @(negedge clk);
      check(term_range_high, m == 0);
      if (m == 0) check(pll_locked, 1'b0);
      n = 0;
      while (link_ready !== 1'b1 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      check(pll_locked, 1'b1);
      @(posedge clk);
      wr(21'h00_0010, {36'h1_2345_6789, 36'h9_8765_4321}, 8'h00);
      wr(21'h1F_FFFF, {36'hA_AAAA_AAAA, 36'h5_5555_5555}, 8'h00);
      wr(21'h00_0010, {36'hF_0F0F_0F0F, 36'h0_F0F0_F0F0}, 8'h96);
      rd(21'h00_0010, m);
      rd(21'h1F_FFFF, m);
      wr(21'h00_0020, {36'h3_3333_3333, 36'hC_CCCC_CCCC}, 8'h00);
      rd(21'h00_0010, m);
      rd(21'h00_0020, m);
    end
    check(lat[0] - lat[1], 12);
    n = 0;
    do @(negedge clk); while (impedance_update !== 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (impedance_update !== 1'b1 && n < 9000);
    check(n, 8192);
    check(drive_code, 6'h15);
    give_verdict();
  end

  // whole run is about 17k clocks, so this only fires on a hang
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : bdr_bench

// ---- sim/bdr_checker.sv ----
module bdr_checker
  import bdr_pkg::*;
(
  input wire logic             clk,                 // sys clock
  input wire logic             srst,                // sync reset
  input wire logic             k,                   // link clock
  input wire logic             load_n,              // command strobe
  input wire logic             read_not_write,      // direction
  input wire logic [BWS_W-1:0] byte_write_select_n, // byte selects
  input wire logic             host_dq_oe,          // host drives dq
  input wire logic             dev_dq_oe,           // device drives dq
  input wire logic             echo_clock,          // echo of k
  input wire logic             echo_clock_n,        // echo of k_n
  input wire logic             read_valid_flag      // read window
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // commands as they stand on the pins
  sequence rd_cmd;
    !load_n && read_not_write;
  endsequence
  sequence wr_cmd;
    !load_n && !read_not_write;
  endsequence

  a_one_driver: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("dq driven from both ends");
  a_read_gap: assert property (rd_cmd |-> not (##[1:24] wr_cmd))
    else $error("write too close after read");
  a_wr_data_slot: assert property ($fell(load_n) && !read_not_write |-> ##[6:8] host_dq_oe)
    else $error("write data not driven in its slot");
  a_cmd_held: assert property ($fell(load_n) |-> (!load_n)[*6])
    else $error("command not held for its slot");
  a_bws_idle: assert property (!host_dq_oe |-> byte_write_select_n == BWS_IDLE)
    else $error("byte selects active with no write data");
  a_float_idle: assert property ((!read_valid_flag)[*8] |-> !dev_dq_oe)
    else $error("device drives dq with no read");
  a_valid_leads: assert property ($rose(dev_dq_oe) |-> $past(read_valid_flag, 3))
    else $error("valid flag did not lead data");
  a_two_words: assert property ($rose(dev_dq_oe) |-> dev_dq_oe[*8])
    else $error("read burst cut short");
  a_echo_tracks: assert property ($rose(k) |-> ##[2:4] $rose(echo_clock))
    else $error("echo clock does not follow k");
  a_echo_pair: assert property ($rose(echo_clock) |-> !echo_clock_n)
    else $error("echo clocks not complementary");
  a_reset_quiet: assert property ($fell(srst) |-> !dev_dq_oe && !read_valid_flag)
    else $error("device not idle after reset");
endmodule : bdr_checker

// ---- src/bdr_device.sv ----
// Local design decisions: the placing of the registers and the address-and-strobe port.
module bdr_device (
  input  wire logic                           clk,                 // system clock
  input  wire logic                           srst,                // sync reset
  bdr_if.dev                                  lnk,                 // memory pins
  input  wire logic [bdr_pkg::ZCODE_W-1:0]    impedance_reference, // resistor code
  output logic                                pll_locked,          // accesses accepted
  output logic                                term_range_high,     // sampled range
  output logic      [bdr_pkg::ZCODE_W-1:0]    drive_code,          // driver impedance
  output logic                                impedance_update     // refresh pulse
);
  import bdr_pkg::*;

  localparam int SW = 4 + BWS_W + ADDR_W + WORD_W + 2 + ZCODE_W;

  logic [SW-1:0]      syn;
  logic               k_s;
  logic               kn_s;
  logic               load_n_s;
  logic               rnw_s;
  logic [BWS_W-1:0]   bws_s;
  logic [ADDR_W-1:0]  addr_s;
  logic [WORD_W-1:0]  d_s;
  logic               pll_on_s;
  logic               term_s;
  logic [ZCODE_W-1:0] zref_s;

  // every pin crosses on the same two flops so clocks and data stay aligned
  bdr_sync #(.W(SW)) u_sync (
    .clk (clk),
    .d   ({lnk.k, lnk.k_n, lnk.load_n, lnk.read_not_write, lnk.byte_write_select_n,
           lnk.addr, lnk.dq, lnk.pll_disable_n, lnk.termination_range_select,
           impedance_reference}),
    .q   (syn)
  );
  assign {k_s, kn_s, load_n_s, rnw_s, bws_s, addr_s, d_s, pll_on_s, term_s, zref_s} = syn;

  logic k_prev_q;
  logic kn_prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      k_prev_q  <= 1'b1;  // host parks k high in reset, no false rise after
      kn_prev_q <= 1'b0;
    end else begin
      k_prev_q  <= k_s;
      kn_prev_q <= kn_s;
    end
  end

  wire k_rise   = k_s & ~k_prev_q;
  wire kn_rise  = kn_s & ~kn_prev_q;
  wire any_edge = (k_s ^ k_prev_q) | (kn_s ^ kn_prev_q);
  wire legacy   = ~pll_on_s;

  // pll model: stall counter and lock timer
  logic [STALL_W-1:0] stall_q;
  logic [LOCK_W-1:0]  lock_q;
  wire                stalled   = (stall_q >= PLL_STALL_CYC);
  wire                lock_done = (lock_q == PLL_LOCK_CYC);

  always_ff @(posedge clk) begin
    if (srst) begin
      stall_q <= '0;
    end else if (any_edge) begin
      stall_q <= '0;
    end else if (!stalled) begin
      stall_q <= stall_q + STALL_W'(1);
    end
  end

  // a stall restarts the lock timer, no separate reset needed
  always_ff @(posedge clk) begin
    if (srst || legacy || stalled) begin
      lock_q <= '0;
    end else if (!lock_done) begin
      lock_q <= lock_q + LOCK_W'(1);
    end
  end

  wire ready  = legacy | lock_done;
  assign pll_locked = ready;

  // command decode on k rise
  wire cmd_ok = k_rise & ready & ~load_n_s;
  wire rd_cmd = cmd_ok & rnw_s;
  wire wr_cmd = cmd_ok & ~rnw_s;

  // read pipeline, one stage per k cycle
  logic [3:1]        rv_q;
  logic [ADDR_W-1:0] ra_q [1:3];

  always_ff @(posedge clk) begin
    if (srst) begin
      rv_q <= '0;
    end else if (k_rise) begin
      rv_q <= {rv_q[2:1], rd_cmd};
    end
  end

  always_ff @(posedge clk) begin
    if (k_rise) begin
      ra_q[1] <= addr_s;
      ra_q[2] <= ra_q[1];
      ra_q[3] <= ra_q[2];
    end
  end

  // write assembly and posted write holding registers
  logic               wp1_q;
  logic               wp2_q;
  logic [ADDR_W-1:0]  wa1_q;
  logic [ADDR_W-1:0]  asm_addr_q;
  logic [WORD_W-1:0]  asm_lo_q;
  logic [BWS_W-1:0]   asm_be_q;
  logic               post_v_q;
  logic [ADDR_W-1:0]  post_addr_q;
  logic [BURST_W-1:0] post_data_q;
  logic [LANES-1:0]   post_be_q;

  wire post_load = kn_rise & wp2_q;
  // the held write goes to the array when the next write begins
  wire commit    = post_v_q & ((k_rise & wr_cmd) | post_load);

  always_ff @(posedge clk) begin
    if (srst) begin
      wp1_q <= 1'b0;
      wp2_q <= 1'b0;
    end else if (k_rise) begin
      wp1_q <= wr_cmd;
      wp2_q <= wp1_q;
    end else if (post_load) begin
      wp2_q <= 1'b0;
    end
  end

  // only the two data edges of a started write look at the data pins
  always_ff @(posedge clk) begin
    if (k_rise) begin
      wa1_q <= addr_s;
    end
    if (k_rise && wp1_q) begin
      asm_addr_q <= wa1_q;
      asm_lo_q   <= d_s;
      asm_be_q   <= ~bws_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      post_v_q <= 1'b0;
    end else if (post_load) begin
      post_v_q <= 1'b1;
    end else if (commit) begin
      post_v_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (post_load) begin
      post_addr_q <= asm_addr_q;
      post_data_q <= {d_s, asm_lo_q};
      post_be_q   <= {~bws_s, asm_be_q};
    end
  end

  // array, one 72-bit burst per address; deselected lanes keep old bytes
  logic [BURST_W-1:0] mem [0:MEM_DEPTH-1];

  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < LANES; i++) begin
        if (post_be_q[i]) begin
          mem[post_addr_q][i*BYTE_W +: BYTE_W] <= post_data_q[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // read fetch with bypass from the posted write
  wire [ADDR_W-1:0]  rd_addr = legacy ? ra_q[1] : ra_q[3];
  wire [BURST_W-1:0] mem_rd  = mem[rd_addr];
  wire               hit     = post_v_q & (post_addr_q == rd_addr);
  logic [BURST_W-1:0] fetch;

  for (genvar g = 0; g < LANES; g++) begin : g_bypass
    assign fetch[g*BYTE_W +: BYTE_W] = (hit && post_be_q[g]) ?
      post_data_q[g*BYTE_W +: BYTE_W] : mem_rd[g*BYTE_W +: BYTE_W];
  end

  // output word timing per latency mode
  wire drive0 = legacy ? (k_rise & rv_q[1]) : (kn_rise & rv_q[3]);
  logic w1_pend_q;
  wire drive1 = w1_pend_q & (legacy ? kn_rise : k_rise);
  wire float_edge = legacy ? (k_rise & ~rv_q[1] & ~w1_pend_q)
                           : (kn_rise & ~rv_q[3]);
  logic [WORD_W-1:0] word1_q;
  logic [WORD_W-1:0] dq_out_q;
  logic              dq_oe_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      w1_pend_q <= 1'b0;
    end else if (drive0) begin
      w1_pend_q <= 1'b1;
    end else if (drive1) begin
      w1_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (drive0) begin
      word1_q <= fetch[BURST_W-1:WORD_W];
    end
  end

  // outputs stay floating from reset until the first read word
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_out_q <= '0;
      dq_oe_q  <= 1'b0;
    end else if (drive0) begin
      dq_out_q <= fetch[WORD_W-1:0];
      dq_oe_q  <= 1'b1;
    end else if (drive1) begin
      dq_out_q <= word1_q;
    end else if (float_edge) begin
      dq_oe_q  <= 1'b0;
    end
  end

  // valid flag leads the first word by one edge and drops after the last
  wire valid_k  = legacy ? rv_q[1] : (rv_q[2] | w1_pend_q);
  wire valid_kn = legacy ? (rv_q[1] | w1_pend_q) : rv_q[3];
  logic valid_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      valid_q <= 1'b0;
    end else if (k_rise) begin
      valid_q <= valid_k;
    end else if (kn_rise) begin
      valid_q <= valid_kn;
    end
  end

  // echo clocks follow the sampled input clocks, same path as the data
  logic echo_q;
  logic echo_n_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      echo_q   <= 1'b0;
      echo_n_q <= 1'b0;
    end else begin
      echo_q   <= k_s;
      echo_n_q <= kn_s;
    end
  end

  assign lnk.dev_dq_out      = dq_out_q;
  assign lnk.dev_dq_oe       = dq_oe_q;
  assign lnk.read_valid_flag = valid_q;
  assign lnk.echo_clock      = echo_q;
  assign lnk.echo_clock_n    = echo_n_q;

  // impedance refresh counted in k cycles from reset release
  logic [IMP_W-1:0]   imp_cnt_q;
  logic [ZCODE_W-1:0] drive_code_q;
  logic               imp_upd_q;
  wire                imp_wrap = k_rise & (imp_cnt_q == IMP_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      imp_cnt_q    <= '0;
      drive_code_q <= ZCODE_RST;
      imp_upd_q    <= 1'b0;
    end else begin
      imp_upd_q <= imp_wrap;
      if (k_rise) begin
        imp_cnt_q <= imp_cnt_q + IMP_W'(1);
      end
      if (imp_wrap) begin
        drive_code_q <= zref_s;
      end
    end
  end

  assign drive_code       = drive_code_q;
  assign impedance_update = imp_upd_q;

  // termination range caught once, a few clocks after reset release
  logic [1:0] init_cnt_q;
  logic       term_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      init_cnt_q <= '0;
      term_q     <= 1'b1;
    end else if (init_cnt_q != TERM_SAMPLE_CYC) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      if (init_cnt_q == TERM_SAMPLE_CYC - 2'h1) begin
        term_q <= term_s;
      end
    end
  end

  assign term_range_high = term_q;
endmodule : bdr_device

// ---- src/bdr_host.sv ----
module bdr_host (
  input  wire logic                           clk,        // system clock
  input  wire logic                           srst,       // sync reset
  bdr_if.host                                 lnk,        // memory pins
  input  wire logic                           req,        // access request
  input  wire logic                           req_write,  // 1 write, 0 read
  input  wire logic [bdr_pkg::ADDR_W-1:0]     req_addr,   // burst address
  input  wire logic [bdr_pkg::BURST_W-1:0]    req_wdata,  // {word1, word0}
  input  wire logic [bdr_pkg::LANES-1:0]      req_be_n,   // byte enables, low writes
  output logic                                req_ready,  // request taken this cycle
  output logic      [bdr_pkg::BURST_W-1:0]    rd_data,    // {word1, word0}
  output logic                                rd_valid,   // read burst pulse
  output logic                                link_ready, // lock time elapsed
  input  wire logic                           pll_enable, // strap for pll pin
  input  wire logic                           term_high   // strap for range pin
);
  import bdr_pkg::*;

  // link clock divider: k high for phases 0 to 3
  logic [2:0] ph_q;
  logic       k_q;
  logic       kn_q;
  wire  [2:0] ph_n = ph_q + 3'h1;

  always_ff @(posedge clk) begin
    if (srst) begin
      ph_q <= '0;
      k_q  <= 1'b1;
      kn_q <= 1'b0;
    end else begin
      ph_q <= ph_n;
      k_q  <= ~ph_n[2];
      kn_q <= ph_n[2];
    end
  end

  // wait for the device pll before the first command
  logic [LOCK_W-1:0] lock_q;
  wire               lock_done = (lock_q == HOST_LOCK_CYC);

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_q <= '0;
    end else if (!lock_done) begin
      lock_q <= lock_q + LOCK_W'(1);
    end
  end

  logic [1:0] gap_q;
  wire        slot  = (ph_q == CMD_PH);
  wire        halfp = (ph_q == HALF_PH);
  // an extra third nop avoids overlap with the last read word
  assign req_ready = slot & lock_done & ~(req_write & (gap_q != 2'h0));
  wire        take  = req & req_ready;
  assign link_ready = lock_done;

  logic                load_n_q;
  logic                rnw_q;
  logic [ADDR_W-1:0]   addr_q;

  // one command per k cycle, load high when idle
  always_ff @(posedge clk) begin
    if (srst) begin
      load_n_q <= 1'b1;
      rnw_q    <= 1'b1;
      addr_q   <= '0;
      gap_q    <= '0;
    end else if (slot) begin
      load_n_q <= ~take;
      if (take) begin
        rnw_q  <= ~req_write;
        addr_q <= req_addr;
      end
      if (take && !req_write) begin
        gap_q <= RD2WR_NOPS;
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end
    end
  end

  // write data: word0 before the next k rise, word1 before k_n rise
  logic                wp1_q;
  logic                wp2_q;
  logic [BURST_W-1:0]  wbuf_q;
  logic [LANES-1:0]    wbe_q;
  logic [WORD_W-1:0]   w1_q;
  logic [BWS_W-1:0]    w1be_q;
  logic [WORD_W-1:0]   dq_q;
  logic                oe_q;
  logic [BWS_W-1:0]    bws_q;

  always_ff @(posedge clk) begin
    if (slot && take && req_write) begin
      wbuf_q <= req_wdata;
      wbe_q  <= req_be_n;
    end
    if (slot && wp1_q) begin
      w1_q   <= wbuf_q[BURST_W-1:WORD_W];
      w1be_q <= wbe_q[LANES-1:BWS_W];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp1_q <= 1'b0;
      wp2_q <= 1'b0;
      dq_q  <= '0;
      oe_q  <= 1'b0;
      bws_q <= BWS_IDLE;
    end else if (slot) begin
      wp1_q <= take & req_write;
      wp2_q <= wp1_q;
      oe_q  <= wp1_q;
      bws_q <= wp1_q ? wbe_q[BWS_W-1:0] : BWS_IDLE;
      if (wp1_q) begin
        dq_q <= wbuf_q[WORD_W-1:0];
      end
    end else if (halfp && wp2_q) begin
      wp2_q <= 1'b0;
      dq_q  <= w1_q;
      bws_q <= w1be_q;
    end
  end

  assign lnk.k                        = k_q;
  assign lnk.k_n                      = kn_q;
  assign lnk.load_n                   = load_n_q;
  assign lnk.read_not_write           = rnw_q;
  assign lnk.addr                     = addr_q;
  assign lnk.byte_write_select_n      = bws_q;
  assign lnk.host_dq_out              = dq_q;
  assign lnk.host_dq_oe               = oe_q;
  assign lnk.pll_disable_n            = pll_enable;
  assign lnk.termination_range_select = term_high;

  // read capture on echo edges while the valid flag held at the edge before
  logic [WORD_W+2:0] rsyn;
  bdr_sync #(.W(WORD_W + 3)) u_rsync (
    .clk (clk),
    .d   ({lnk.echo_clock, lnk.echo_clock_n, lnk.read_valid_flag, lnk.dq}),
    .q   (rsyn)
  );
  wire              e_s  = rsyn[WORD_W+2];
  wire              en_s = rsyn[WORD_W+1];
  wire              v_s  = rsyn[WORD_W];
  wire [WORD_W-1:0] q_s  = rsyn[WORD_W-1:0];

  logic              e_prev_q;
  logic              en_prev_q;
  logic              v_prev_q;
  logic              half_q;
  logic [WORD_W-1:0] lo_q;
  logic [BURST_W-1:0] rd_data_q;
  logic              rd_valid_q;
  wire               eedge = (e_s & ~e_prev_q) | (en_s & ~en_prev_q);
  wire               cap   = eedge & v_s & v_prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      e_prev_q   <= 1'b0;
      en_prev_q  <= 1'b0;
      v_prev_q   <= 1'b0;
      half_q     <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      e_prev_q   <= e_s;
      en_prev_q  <= en_s;
      rd_valid_q <= cap & half_q;
      if (eedge) begin
        v_prev_q <= v_s;
        half_q   <= cap & ~half_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (cap && !half_q) begin
      lo_q <= q_s;
    end
    if (cap && half_q) begin
      rd_data_q <= {q_s, lo_q};
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;
endmodule : bdr_host

// ---- src/bdr_if.sv ----
interface bdr_if;
  import bdr_pkg::*;
  logic                k;
  logic                k_n;
  logic [ADDR_W-1:0]   addr;
  logic                load_n;
  logic                read_not_write;
  logic [BWS_W-1:0]    byte_write_select_n;
  logic [WORD_W-1:0]   host_dq_out;
  logic                host_dq_oe;
  logic [WORD_W-1:0]   dev_dq_out;
  logic                dev_dq_oe;
  logic [WORD_W-1:0]   dq;
  logic                echo_clock;
  logic                echo_clock_n;
  logic                read_valid_flag;
  logic                pll_disable_n;
  logic                termination_range_select;

  // shared data wire, no driver reads as zero
  assign dq = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : 36'h0_0000_0000);

  modport dev (
    input  k, k_n, addr, load_n, read_not_write, byte_write_select_n, dq,
    input  pll_disable_n, termination_range_select,
    output dev_dq_out, dev_dq_oe, echo_clock, echo_clock_n, read_valid_flag
  );
  modport host (
    output k, k_n, addr, load_n, read_not_write, byte_write_select_n,
    output host_dq_out, host_dq_oe, pll_disable_n, termination_range_select,
    input  dq, echo_clock, echo_clock_n, read_valid_flag
  );
endinterface : bdr_if

// ---- src/bdr_pkg.sv ----
package bdr_pkg;
  // array shape: one address holds a two-word burst
  localparam int ADDR_W    = 21;
  localparam int WORD_W    = 36;
  localparam int BURST_W   = 2 * WORD_W;
  localparam int BYTE_W    = 9;
  localparam int LANES     = BURST_W / BYTE_W;
  localparam int BWS_W     = 4;
  localparam int ZCODE_W   = 6;
  localparam int MEM_DEPTH = 2 ** ADDR_W;

  // system clock and link clock divider
  localparam int CLK_NS     = 50;
  localparam int K_HALF_CYC = 4;
  localparam logic [2:0] CMD_PH  = 3'h5;  // host changes commands two clocks before k rises
  localparam logic [2:0] HALF_PH = 3'h1;  // and second words two clocks before k_n rises

  // pll lock and stall detection
  localparam int LOCK_W      = 9;
  localparam int PLL_LOCK_US = 20;
  localparam logic [LOCK_W-1:0] PLL_LOCK_CYC =
    LOCK_W'((PLL_LOCK_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [LOCK_W-1:0] HOST_LOCK_CYC = PLL_LOCK_CYC + LOCK_W'(16);
  localparam int KSTOP_NS  = 30;
  localparam int STALL_W   = 4;
  localparam logic [STALL_W-1:0] PLL_STALL_CYC =
    STALL_W'(K_HALF_CYC + (KSTOP_NS + CLK_NS - 1) / CLK_NS);

  // impedance update period in k cycles, strap sampling delay
  localparam int IMP_W = 10;
  localparam logic [IMP_W-1:0] IMP_LAST = 10'h03FF;
  localparam logic [1:0] TERM_SAMPLE_CYC = 2'h3;

  // host gap and reset values
  localparam logic [1:0] RD2WR_NOPS = 2'h3;
  localparam logic [BWS_W-1:0] BWS_IDLE = 4'hF;
  localparam logic [ZCODE_W-1:0] ZCODE_RST = 6'h20;
endpackage : bdr_pkg

// ---- src/bdr_sync.sv ----
module bdr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // sampling clock
  input  wire logic [W-1:0] d,    // asynchronous inputs
  output logic      [W-1:0] q     // synchronised outputs
);
  logic [W-1:0] meta_q;

  // no reset so the strap pins are already settled when reset drops
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : bdr_sync
